// ==== design/pie_pkg.sv ====
// constants of the peripheral interrupt enable block
// assumes an axi4-lite master on aclk and synchronous request flags from peripherals
package pie_pkg;
  localparam logic [7:0] PIE_OFS_EN1 = 8'h00;
  localparam logic [7:0] PIE_OFS_EN2 = 8'h04;
  localparam logic [7:0] PIE_OFS_CORE = 8'h08;
  localparam logic [7:0] PIE_OFS_STATUS = 8'h0C;
  localparam logic [7:0] PIE_OFS_CLEAR = 8'h10;
  localparam logic [7:0] PIE_OFS_IRQEN = 8'h14;
  localparam logic [7:0] PIE_OFS_PINCHG = 8'h18;
  localparam logic [7:0] PIE_EN1_RESET = 8'h00;
  localparam logic [7:0] PIE_EN2_RESET = 8'h00;
  localparam logic [7:0] PIE_EN2_MASK = 8'h89;
  localparam int PIE_CORE_GLOBAL_BIT = 7;
  localparam int PIE_CORE_GROUP_BIT = 6;
  localparam int PIE_CORE_SUMMARY_BIT = 0;
  localparam logic [1:0] PIE_RESP_OKAY = 2'h0;
  localparam logic [1:0] PIE_RESP_SLVERR = 2'h2;
  // status events: 0 request to core, 1 summary flag fell, 2 wake from sleep
  localparam int PIE_NEV = 3;
  localparam int PIE_EV_REQ = 0;
  localparam int PIE_EV_SUMFALL = 1;
  localparam int PIE_EV_WAKE = 2;
endpackage : pie_pkg

// ==== design/pie_top.sv ====
// peripheral interrupt enables with axi4-lite register access
// assumes request flags are held by the peripherals until their software clears them
`timescale 1ns/1ns
module pie_top
  import pie_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // peripheral request flags
  input wire logic [7:0] req_flags_one,
  input wire logic [7:0] req_flags_two,
  input wire logic [7:0] pin_change_flag_register,
  // core
  input wire logic core_asleep,
  output logic periph_irq_req,
  output logic wake_req,
  output logic wake_vector,
  output logic pin_change_summary_flag,
  output logic irq
);

  typedef struct packed {
    // write side
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    // read side
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // enables
    logic [7:0] en_one;
    logic [7:0] en_two;
    logic global_irq_enable;
    logic peripheral_group_enable;
    // toward the core
    logic summary;
    logic periph_req;
    logic wake;
    logic wake_vec;
    // sticky events
    logic [PIE_NEV-1:0] status;
    logic [PIE_NEV-1:0] irq_en;
    logic irq;
  } pie_state_type;

  pie_state_type s_r;
  pie_state_type s_nxt;

  function automatic logic [31:0] pie_zext8(input logic [7:0] v);
    pie_zext8 = {24'h000000, v};
  endfunction : pie_zext8

  function automatic logic [31:0] pie_zext3(input logic [PIE_NEV-1:0] v);
    pie_zext3 = {29'h0, v};
  endfunction : pie_zext3

  // unimplemented bits of enable two can never hold a one
  function automatic logic [7:0] pie_en2_bits(input logic [7:0] v);
    pie_en2_bits = v & PIE_EN2_MASK;
  endfunction : pie_en2_bits

  function automatic logic pie_rise(input logic prev, input logic cur);
    pie_rise = cur && !prev;
  endfunction : pie_rise

  logic any_en_req;
  logic group_req;
  logic [PIE_NEV-1:0] ev;
  logic do_write;
  logic [7:0] wlo;

  always_comb begin
    s_nxt = s_r;
    // flag and individual enable must both be set
    any_en_req = |((req_flags_one & s_r.en_one)
                   | (req_flags_two & pie_en2_bits(s_r.en_two)));
    // wake and vectoring both hang off the group enable
    group_req = any_en_req && s_r.peripheral_group_enable;
    ev = '0;
    do_write = 1'b0;
    wlo = s_r.w_data[7:0];
    // write channel: address and data taken in either order
    // ready shows only once a half is held, so the master keeps it stable until then
    if (awvalid && !s_r.aw_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = awaddr;
    end
    if (wvalid && !s_r.w_got && !s_r.bvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
    end
    if (s_r.aw_got && s_r.w_got) begin
      // only byte lane 0 carries register bits; upper lanes are dropped
      do_write = s_r.w_strb[0];
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = PIE_RESP_OKAY;
      case (s_r.aw_addr)
        PIE_OFS_EN1: begin
          if (do_write) s_nxt.en_one = wlo;
        end
        PIE_OFS_EN2: begin
          if (do_write) s_nxt.en_two = pie_en2_bits(wlo);
        end
        PIE_OFS_CORE: begin
          if (do_write) begin
            s_nxt.global_irq_enable = wlo[PIE_CORE_GLOBAL_BIT];
            s_nxt.peripheral_group_enable = wlo[PIE_CORE_GROUP_BIT];
          end
        end
        PIE_OFS_CLEAR: begin
          if (do_write) s_nxt.status = s_r.status & ~wlo[PIE_NEV-1:0];
        end
        PIE_OFS_IRQEN: begin
          if (do_write) s_nxt.irq_en = wlo[PIE_NEV-1:0];
        end
        PIE_OFS_STATUS, PIE_OFS_PINCHG: begin
          // read-only: write ignored, summary flag cannot be written
        end
        default: begin
          s_nxt.bresp = PIE_RESP_SLVERR;
        end
      endcase
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // read channel: no wait states, arready and rvalid rise together
    if (arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = PIE_RESP_OKAY;
      case (araddr)
        PIE_OFS_EN1: s_nxt.rdata = pie_zext8(s_r.en_one);
        PIE_OFS_EN2: s_nxt.rdata = pie_zext8(pie_en2_bits(s_r.en_two));
        PIE_OFS_CORE: begin
          s_nxt.rdata = '0;
          s_nxt.rdata[PIE_CORE_GLOBAL_BIT] = s_r.global_irq_enable;
          s_nxt.rdata[PIE_CORE_GROUP_BIT] = s_r.peripheral_group_enable;
          s_nxt.rdata[PIE_CORE_SUMMARY_BIT] = s_r.summary;
        end
        PIE_OFS_STATUS: s_nxt.rdata = pie_zext3(s_r.status);
        PIE_OFS_IRQEN: s_nxt.rdata = pie_zext3(s_r.irq_en);
        PIE_OFS_PINCHG: s_nxt.rdata = pie_zext8(pin_change_flag_register);
        PIE_OFS_CLEAR: s_nxt.rdata = '0;
        default: begin
          s_nxt.rdata = '0;
          s_nxt.rresp = PIE_RESP_SLVERR;
        end
      endcase
    end
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // summary follows the per-pin flags, so it only falls once all are cleared
    s_nxt.summary = |pin_change_flag_register;
    // all four conditions needed toward the core
    s_nxt.periph_req = group_req && s_r.global_irq_enable;
    // wake needs enabled sources and the group enable; vectoring also needs global enable,
    // otherwise the core just resumes after its sleep instruction
    s_nxt.wake = core_asleep && group_req;
    s_nxt.wake_vec = core_asleep && group_req && s_r.global_irq_enable;
    ev[PIE_EV_REQ] = pie_rise(s_r.periph_req, s_nxt.periph_req);
    ev[PIE_EV_SUMFALL] = pie_rise(s_nxt.summary, s_r.summary);
    ev[PIE_EV_WAKE] = pie_rise(s_r.wake, s_nxt.wake);
    // set wins over a clear in the same cycle
    s_nxt.status = s_nxt.status | ev;
    s_nxt.irq = |(s_nxt.status & s_nxt.irq_en);
    if (!aresetn) begin
      s_nxt = '0;
      s_nxt.en_one = PIE_EN1_RESET;
      s_nxt.en_two = PIE_EN2_RESET;
      s_nxt.global_irq_enable = 1'b0;
      s_nxt.peripheral_group_enable = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  assign awready = s_r.aw_got;
  assign wready = s_r.w_got;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.rvalid;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign periph_irq_req = s_r.periph_req;
  assign wake_req = s_r.wake;
  assign wake_vector = s_r.wake_vec;
  assign pin_change_summary_flag = s_r.summary;
  assign irq = s_r.irq;

endmodule : pie_top

// ==== verif/pie_monitor.sv ====
// assertions on pie_top ports
// assumes one clock and a sync active-low reset
`timescale 1ns/1ns
module pie_monitor
  import pie_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // reads
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  // core side
  input wire logic [7:0] pin_change_flag_register,
  input wire logic [7:0] req_flags_one,
  input wire logic [7:0] req_flags_two,
  input wire logic core_asleep,
  input wire logic periph_irq_req,
  input wire logic wake_req,
  input wire logic wake_vector,
  input wire logic pin_change_summary_flag,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_sum; $past(aresetn) |-> pin_change_summary_flag == |$past(pin_change_flag_register);
  endproperty
  a_sum: assert property (p_sum) else $error("summary flag");
  property p_en2; arvalid && !rvalid && araddr == PIE_OFS_EN2 |=> (rdata & 32'h76) == 32'h0;
  endproperty
  a_en2: assert property (p_en2) else $error("unused bits set");
  property p_vec; wake_vector |-> wake_req || $past(wake_req); endproperty
  a_vec: assert property (p_vec) else $error("vector without wake");
  property p_wake; !core_asleep |=> !wake_req; endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_rst; $rose(aresetn) |-> !irq && !periph_irq_req && !wake_req; endproperty
  a_rst: assert property (p_rst) else $error("active after reset");
  property p_req;
    $past(aresetn) && periph_irq_req |-> |$past(req_flags_one) || |$past(req_flags_two);
  endproperty
  a_req: assert property (p_req) else $error("request without flag");
  property p_vecreq; wake_vector |-> periph_irq_req; endproperty
  a_vecreq: assert property (p_vecreq) else $error("vector without global enable");
  c_req: cover property (periph_irq_req);
  c_vec: cover property (wake_vector);
  c_irq: cover property (irq);
endmodule : pie_monitor
bind pie_top pie_monitor u_mon(.*);

// ==== verif/pie_periph.sv ====
// request sources and core sleep as seen by pie_top
// assumes the bench sets the wanted pattern after an edge
`timescale 1ns/1ns
module pie_periph (
  // clock and wanted pattern
  input wire logic aclk,
  input wire logic [7:0] f1s,
  input wire logic [7:0] f2s,
  input wire logic [7:0] pns,
  input wire logic slp,
  // toward the block
  output logic [7:0] req_flags_one,
  output logic [7:0] req_flags_two,
  output logic [7:0] pin_change_flag_register,
  output logic core_asleep
);
  // flags are levels held until the bench changes its pattern, one edge later
  always_ff @(posedge aclk) begin
    {req_flags_one, req_flags_two} <= {f1s, f2s};
    pin_change_flag_register <= pns;
    core_asleep <= slp;
  end
endmodule : pie_periph

// ==== verif/peripheral_interrupt_enables_tb_top.sv ====
// random and corner traffic through pie_top
// assumes pie_pkg, pie_top, pie_periph, pie_monitor
`timescale 1ns/1ns
module peripheral_interrupt_enables_tb_top
  import pie_pkg::*;
;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, slp = 0, core_asleep, awready, wready, bvalid, arready, rvalid;
  logic periph_irq_req, wake_req, wake_vector, pin_change_summary_flag, irq;
  logic [7:0] awaddr = 0, araddr = 0, f1s = 0, f2s = 0, pns = 0;
  logic [7:0] req_flags_one, req_flags_two, pin_change_flag_register;
  logic [31:0] wdata = 0, rdata, rd_d;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  int failures = 0, n_tests = 0, cyc = 0;
  always #10 aclk = ~aclk;
  pie_periph u_per(.*);
  pie_top u_dut(.*);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hF, 3'h7};
    // each channel is let go on its own ready; bready stays up until bvalid
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    wr_r = bresp;
    bready <= 1'h0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    {rd_r, rd_d} = {rresp, rdata};
    rready <= 1'h0;
  endtask : rd
  function automatic logic [2:0] exp_out(input logic [7:0] e1, e2, a1, a2,
      input logic [1:0] c, input logic s);
    logic hit;
    hit = |((e1 & a1) | (e2 & a2 & 8'h89));
    return {hit & c[1] & c[0], s & hit & c[0], s & hit & c[1] & c[0]};
  endfunction : exp_out
  function automatic logic [31:0] core_word(input logic [1:0] c);
    core_word = '0;
    core_word[PIE_CORE_GLOBAL_BIT] = c[1];
    core_word[PIE_CORE_GROUP_BIT] = c[0];
  endfunction : core_word
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    logic [7:0] e1, e2, a1, a2, p;
    logic [1:0] c;
    logic s;
    void'($urandom(64));
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(PIE_OFS_EN1);
    chk(rd_d, 32'h0);
    wr(PIE_OFS_EN2, 32'hFFFFFFFF);
    chk(wr_r, PIE_RESP_OKAY);
    rd(PIE_OFS_EN2);
    chk(rd_d, 32'h89);
    rd(8'h40);
    chk(rd_r, PIE_RESP_SLVERR);
    wr(8'h40, 32'h0);
    chk(wr_r, PIE_RESP_SLVERR);
    for (int i = 0; i < 40; i++) begin
      {e1, e2, a1, a2} = $urandom;
      {p, c, s} = 11'($urandom);
      // one enable bit at a time first, unused bits of enable two included
      if (i < 16) begin
        {e1, e2} = 16'h1 << i;
        {a1, a2, c} = {16'hFFFF, 2'h3};
      end
      {f1s, f2s, pns, slp} <= {a1, a2, p, s};
      wr(PIE_OFS_EN1, {24'h0, e1});
      wr(PIE_OFS_EN2, {24'h0, e2});
      wr(PIE_OFS_CORE, core_word(c));
      repeat (3) @(posedge aclk);
      chk({periph_irq_req, wake_req, wake_vector}, exp_out(e1, e2, a1, a2, c, s));
      chk(pin_change_summary_flag, |p);
    end
    {f1s, pns, slp} <= {8'h01, 8'h00, 1'h0};
    wr(PIE_OFS_EN1, 32'h1);
    wr(PIE_OFS_CORE, core_word(2'h0));
    wr(PIE_OFS_IRQEN, 32'h1);
    wr(PIE_OFS_CLEAR, 32'h7);
    repeat (2) @(posedge aclk);
    chk(irq, 32'h0);
    wr(PIE_OFS_CORE, core_word(2'h3));
    repeat (2) @(posedge aclk);
    chk(irq, 32'h1);
    wr(PIE_OFS_IRQEN, 32'h0);
    repeat (2) @(posedge aclk);
    chk(irq, 32'h0);
    // summary bit ignores writes
    wr(PIE_OFS_CORE, 32'h1 << PIE_CORE_SUMMARY_BIT);
    rd(PIE_OFS_CORE);
    chk(rd_d, 32'h0);
    // reset in mid-run clears every enable
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(PIE_OFS_EN1);
    chk(rd_d, 32'h0);
    chk(periph_irq_req, 1'h0);
    tally_and_finish();
  end
endmodule : peripheral_interrupt_enables_tb_top
